// [shared/ciacu_pkg.sv]
package ciacu_pkg;

	// ==========================================
	// Register map (byte addresses)
	localparam int         ADDR_W    = 8;
	localparam logic [7:0] OFS_CMD   = 8'h00;
	localparam logic [7:0] OFS_FLAGS = 8'h04;
	localparam logic [7:0] OFS_PC    = 8'h08;
	localparam logic [7:0] OFS_SP    = 8'h0c;
	localparam logic [7:0] OFS_STAT  = 8'h10;
	localparam logic [7:0] OFS_GPR   = 8'h20;

	// ==========================================
	// Command word bits
	localparam int CMD_EI  = 0;
	localparam int CMD_DI  = 1;
	localparam int CMD_SIM = 2;
	localparam int CMD_RIM = 3;

	// ==========================================
	// Mask image layouts
	localparam int SIM_SOD  = 7;
	localparam int SIM_SOE  = 6;
	localparam int SIM_R75  = 4;
	localparam int SIM_MSE  = 3;
	localparam int RIM_SID  = 7;
	localparam int RIM_IE   = 3;
	localparam int MASK_A   = 0;
	localparam int MASK_B   = 1;
	localparam int MASK_C   = 2;

	// ==========================================
	// Status word bits
	localparam int STAT_IE   = 3;
	localparam int STAT_RCP  = 4;
	localparam int STAT_NMI  = 5;
	localparam int STAT_HOLD = 6;
	localparam int STAT_BUSY = 7;
	localparam int STAT_SOD  = 8;

	// ==========================================
	// Register codes, reset values, vectors
	localparam logic [2:0]  CODE_M     = 3'h6;
	localparam logic [2:0]  CODE_A     = 3'h7;
	localparam logic [7:0]  FLAGS_USED = 8'hd5;
	localparam logic [2:0]  MASK_RST   = 3'h7;
	localparam logic [15:0] PC_RST     = 16'h0000;
	localparam logic [15:0] SP_RST     = 16'h0000;
	localparam logic [15:0] VEC_NMI    = 16'h0024;
	localparam logic [15:0] VEC_RC     = 16'h003c;
	localparam logic [15:0] VEC_RB     = 16'h0034;
	localparam logic [15:0] VEC_RA     = 16'h002c;
	localparam logic [15:0] RST_SPACE  = 16'h0008;

	// ==========================================
	// Timing
	localparam int OSC_DIV = 2;
	localparam int SYNC_W  = 15;

	typedef enum logic [2:0] {SRC_NONE, SRC_NMI, SRC_RC, SRC_RB, SRC_RA, SRC_GEN} ciacu_src_e;
	typedef enum logic [2:0] {SQ_IDLE, SQ_ACK1, SQ_ACK2, SQ_ACK3, SQ_PSH1, SQ_PSH2, SQ_PSH3} ciacu_seq_e;

endpackage : ciacu_pkg

// [shared/ciacu_pin_if.sv]
`timescale 1ns/10ps
interface ciacu_pin_if;
	logic       tick;
	logic       nmi;
	logic       rc;
	logic       rb;
	logic       ra;
	logic       gen;
	logic       sin;
	logic       hold;
	logic [7:0] ad;

	modport div  (output tick);
	modport src  (output nmi, rc, rb, ra, gen, sin, hold, ad);
	modport core (input tick, nmi, rc, rb, ra, gen, sin, hold, ad);
endinterface : ciacu_pin_if

// [hdl/ciacu_sync.sv]
`timescale 1ns/10ps
module ciacu_sync (
	// Clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       resetn_i,
	// Raw pins and synchronised view
	input  wire logic [ciacu_pkg::SYNC_W-1:0] pins_i,
	ciacu_pin_if.src                        pif
);
	import ciacu_pkg::*;

	logic [SYNC_W-1:0] s1_r;
	logic [SYNC_W-1:0] s2_r;
	logic [SYNC_W-1:0] s3_r;
	logic [SYNC_W-1:0] stable_r;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= pins_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// A change counts only once two late stages agree
	for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
		always_ff @(posedge clk_i) begin
			if (!resetn_i)
				stable_r[i] <= 1'b0;
			else if (s2_r[i] == s3_r[i])
				stable_r[i] <= s3_r[i];
		end
	end

	assign {pif.ad, pif.hold, pif.sin, pif.gen, pif.ra, pif.rb, pif.rc, pif.nmi} = stable_r;

endmodule : ciacu_sync

// [hdl/ciacu_clkdiv.sv]
`timescale 1ns/10ps
module ciacu_clkdiv (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic resetn_i,
	// Processor state enable
	ciacu_pin_if.div  pif
);
	import ciacu_pkg::*;

	logic [1:0] cnt_r;

	// Only the sequencer steps and the request take wait for this enable; other flops load on any clock edge
	always_ff @(posedge clk_i) begin
		if (!resetn_i)
			cnt_r <= 2'h0;
		else if (cnt_r == 2'(OSC_DIV - 1))
			cnt_r <= 2'h0;
		else
			cnt_r <= cnt_r + 2'h1;
	end

	assign pif.tick = (cnt_r == 2'(OSC_DIV - 1));

endmodule : ciacu_clkdiv

// [hdl/ciacu_top.sv]
// Summary of operation
// - Five request inputs: general, restarts a, b, c, and non-maskable.
// - General request fetches an external restart opcode; target is 0..56 step 8.
// - Every restart pushes the program counter on the stack, then branches.
// - Restart a, b, c taken only with enable set and own mask clear.
// - Non-maskable request ignores the enable flag and every mask.
// - Restarts a, b are level sampled like general; c is rising edge.
// - Edge on c sets a pending flop; cleared by service, set-mask or reset.
// - The c pending flop sets even while c is masked.
// - Mask bits change only by set-mask or reset.
// - Priority: non-maskable, c, b, a, then general request.
// - Priority ignores which service routine is running.
// - Non-maskable needs a rising edge plus held level; rearms after going low.
// - Servicing any request clears the enable until an enable op.
// - Non-maskable saves prior enable; first read-mask returns it, later ones current.
// - Read-mask after other service reports current, disabled, enable state.
// - Read-mask captures the serial input; set-mask updates serial output latch.
// - Hold and all request inputs are synchronised before use.
// - Processor state rate is half the oscillator input rate.
// - Fully static: clock may stop in either level indefinitely.
// - First state drives low address and address strobe; later states carry data.
// - Register codes: B 000, C 001, D 010, E 011, H 100, L 101, memory 110, A 111.
// - Accumulator, five flags, six general registers, program counter, stack pointer.
// - Internal vectors: non-maskable 24h, c 3ch, b 34h, a 2ch.
`timescale 1ns/10ps
module ciacu_top (
	// Clock and reset
	input  wire logic                         SYS_CLK_I,
	input  wire logic                         RESETN_I,
	// APB slave
	input  wire logic                         PSEL_I,
	input  wire logic                         PENABLE_I,
	input  wire logic                         PWRITE_I,
	input  wire logic [ciacu_pkg::ADDR_W-1:0] PADDR_I,
	input  wire logic [31:0]                  PWDATA_I,
	output      logic [31:0]                  PRDATA_O,
	output      logic                         PREADY_O,
	output      logic                         PSLVERR_O,
	// Request pins
	input  wire logic                         NMI_REQ_I,
	input  wire logic                         RESTART_C_I,
	input  wire logic                         RESTART_B_I,
	input  wire logic                         RESTART_A_I,
	input  wire logic                         GENERAL_REQUEST_I,
	input  wire logic                         HOLD_REQ_I,
	// Serial bits
	input  wire logic                         SERIAL_IN_LINE_I,
	output      logic                         SERIAL_OUT_LINE_O,
	// Multiplexed bus
	input  wire logic [7:0]                   AD_I,
	output      logic [7:0]                   AD_O,
	output      logic                         AD_OE_O,
	output      logic [7:0]                   ADDR_HI_O,
	output      logic                         ALE_O,
	output      logic                         WR_N_O,
	output      logic                         IRQ_ACK_STROBE_N_O
);
	import ciacu_pkg::*;

	// ==========================================
	// Input synchronisers and state enable
	ciacu_pin_if pif ();

	ciacu_sync u_sync (
		.clk_i    (SYS_CLK_I),
		.resetn_i (RESETN_I),
		.pins_i   ({AD_I, HOLD_REQ_I, SERIAL_IN_LINE_I, GENERAL_REQUEST_I,
		            RESTART_A_I, RESTART_B_I, RESTART_C_I, NMI_REQ_I}),
		.pif      (pif)
	);

	ciacu_clkdiv u_div (
		.clk_i    (SYS_CLK_I),
		.resetn_i (RESETN_I),
		.pif      (pif)
	);

	// ==========================================
	// Declarations
	ciacu_seq_e  state_r;
	ciacu_src_e  src;
	logic        hi_r;
	logic        vec_ld_r;
	logic [15:0] vec_r;
	logic [15:0] pc_r;
	logic [15:0] sp_r;
	logic [15:0] bus_addr;
	logic [7:0]  acc_r;
	logic [7:0]  flags_r;
	logic [7:0]  gpr_r [6];
	logic [2:0]  mask_r;
	logic        ie_r;
	logic        saved_ie_r;
	logic        rim_saved_r;
	logic        sod_r;
	logic        nmi_prev_r;
	logic        nmi_lat_r;
	logic        rc_prev_r;
	logic        rc_pend_r;
	logic        err_r;
	logic [31:0] rdata_r;
	logic [31:0] rd_mux;
	logic        busy;
	logic        take;
	logic        setup;
	logic        wr_go;
	logic        pcsp_sel;
	logic        ei_go;
	logic        di_go;
	logic        sim_go;
	logic        rim_go;
	logic        rc_clr;
	logic        ie_img;

	// ==========================================
	// Address decode helpers
	function automatic logic is_gpr(input logic [ADDR_W-1:0] a);
		return (a[ADDR_W-1:5] == OFS_GPR[ADDR_W-1:5]) && (a[1:0] == 2'h0);
	endfunction : is_gpr

	function automatic logic [2:0] gpr_code(input logic [ADDR_W-1:0] a);
		return a[4:2];
	endfunction : gpr_code

	function automatic logic addr_bad(input logic [ADDR_W-1:0] a, input logic wr, input logic bsy);
		logic ok;
		ok = (a == OFS_CMD) || (a == OFS_FLAGS) || (a == OFS_PC) || (a == OFS_SP) || (a == OFS_STAT);
		ok = ok || (is_gpr(a) && (gpr_code(a) != CODE_M));
		// Stack and counter belong to the sequencer while it acknowledges or pushes
		if (wr && bsy && ((a == OFS_PC) || (a == OFS_SP)))
			ok = 1'b0;
		if (wr && (a == OFS_STAT))
			ok = 1'b0;
		return !ok;
	endfunction : addr_bad

	function automatic logic [15:0] fixed_vec(input ciacu_src_e s);
		unique case (s)
			SRC_NMI: return VEC_NMI;
			SRC_RC:  return VEC_RC;
			SRC_RB:  return VEC_RB;
			SRC_RA:  return VEC_RA;
			default: return PC_RST;
		endcase
	endfunction : fixed_vec

	// ==========================================
	// APB slave
	assign busy     = (state_r != SQ_IDLE);
	assign setup    = PSEL_I && !PENABLE_I;
	assign wr_go    = PSEL_I && PENABLE_I && PWRITE_I && !err_r;
	assign pcsp_sel = PSEL_I && ((PADDR_I == OFS_PC) || (PADDR_I == OFS_SP));
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = PSEL_I && PENABLE_I && err_r;
	assign PRDATA_O = rdata_r;

	assign ei_go  = wr_go && (PADDR_I == OFS_CMD) && PWDATA_I[CMD_EI];
	assign di_go  = wr_go && (PADDR_I == OFS_CMD) && PWDATA_I[CMD_DI];
	assign sim_go = wr_go && (PADDR_I == OFS_CMD) && PWDATA_I[CMD_SIM];
	assign rim_go = wr_go && (PADDR_I == OFS_CMD) && PWDATA_I[CMD_RIM];

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (PADDR_I == OFS_FLAGS)
			rd_mux[7:0] = flags_r & FLAGS_USED;
		else if (PADDR_I == OFS_PC)
			rd_mux[15:0] = pc_r;
		else if (PADDR_I == OFS_SP)
			rd_mux[15:0] = sp_r;
		else if (PADDR_I == OFS_STAT)
			rd_mux[STAT_SOD:0] = {sod_r, busy, pif.hold, nmi_lat_r, rc_pend_r, ie_r, mask_r};
		else if (is_gpr(PADDR_I) && (gpr_code(PADDR_I) == CODE_A))
			rd_mux[7:0] = acc_r;
		else if (is_gpr(PADDR_I) && (gpr_code(PADDR_I) != CODE_M))
			rd_mux[7:0] = gpr_r[gpr_code(PADDR_I)];
	end

	// Answer is sampled in setup so the access phase sees stable flops
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			err_r   <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else if (setup) begin
			err_r   <= addr_bad(PADDR_I, PWRITE_I, busy);
			rdata_r <= PWRITE_I ? 32'h0000_0000 : rd_mux;
		end
	end

	// ==========================================
	// Request capture
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			nmi_prev_r <= 1'b0;
			rc_prev_r  <= 1'b0;
		end else begin
			nmi_prev_r <= pif.nmi;
			rc_prev_r  <= pif.rc;
		end
	end

	// Edge arms the latch, the held level keeps the request alive
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I)
			nmi_lat_r <= 1'b0;
		else if (pif.nmi && !nmi_prev_r)
			nmi_lat_r <= 1'b1;
		else if (take && (src == SRC_NMI))
			nmi_lat_r <= 1'b0;
	end

	assign rc_clr = (take && (src == SRC_RC)) || (sim_go && acc_r[SIM_R75]);

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I)
			rc_pend_r <= 1'b0;
		else if (pif.rc && !rc_prev_r)
			rc_pend_r <= 1'b1;
		else if (rc_clr)
			rc_pend_r <= 1'b0;
	end

	// ==========================================
	// Priority resolution
	always_comb begin
		src = SRC_NONE;
		if (nmi_lat_r && pif.nmi)
			src = SRC_NMI;
		else if (ie_r && !mask_r[MASK_C] && rc_pend_r)
			src = SRC_RC;
		else if (ie_r && !mask_r[MASK_B] && pif.rb)
			src = SRC_RB;
		else if (ie_r && !mask_r[MASK_A] && pif.ra)
			src = SRC_RA;
		else if (ie_r && pif.gen)
			src = SRC_GEN;
	end

	// Held off while the master points at the counter or stack pointer
	assign take = (state_r == SQ_IDLE) && pif.tick && (src != SRC_NONE) && !pcsp_sel;

	// ==========================================
	// Enable flag and saved copy
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I)
			ie_r <= 1'b0;
		else if (take)
			ie_r <= 1'b0;
		else if (di_go)
			ie_r <= 1'b0;
		else if (ei_go)
			ie_r <= 1'b1;
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			saved_ie_r  <= 1'b0;
			rim_saved_r <= 1'b0;
		end else if (take && (src == SRC_NMI)) begin
			saved_ie_r  <= ie_r;
			rim_saved_r <= 1'b1;
		end else if (rim_go) begin
			rim_saved_r <= 1'b0;
		end
	end

	assign ie_img = rim_saved_r ? saved_ie_r : ie_r;

	// ==========================================
	// Mask and serial output
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I)
			mask_r <= MASK_RST;
		else if (sim_go && acc_r[SIM_MSE])
			mask_r <= acc_r[MASK_C:MASK_A];
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I)
			sod_r <= 1'b0;
		else if (sim_go && acc_r[SIM_SOE])
			sod_r <= acc_r[SIM_SOD];
	end

	assign SERIAL_OUT_LINE_O = sod_r;

	// ==========================================
	// Accumulator, flags, general registers
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I)
			acc_r <= 8'h00;
		else if (rim_go)
			acc_r <= {pif.sin, rc_pend_r, pif.rb, pif.ra, ie_img, mask_r};
		else if (wr_go && is_gpr(PADDR_I) && (gpr_code(PADDR_I) == CODE_A))
			acc_r <= PWDATA_I[7:0];
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I)
			flags_r <= 8'h00;
		else if (wr_go && (PADDR_I == OFS_FLAGS))
			flags_r <= PWDATA_I[7:0] & FLAGS_USED;
	end

	for (genvar g = 0; g < 6; g++) begin : g_gpr
		always_ff @(posedge SYS_CLK_I) begin
			if (!RESETN_I)
				gpr_r[g] <= 8'h00;
			else if (wr_go && is_gpr(PADDR_I) && (gpr_code(PADDR_I) == 3'(g)))
				gpr_r[g] <= PWDATA_I[7:0];
		end
	end

	// ==========================================
	// Restart sequencer
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			state_r <= SQ_IDLE;
			hi_r    <= 1'b0;
			vec_ld_r <= 1'b0;
			vec_r   <= PC_RST;
			pc_r    <= PC_RST;
			sp_r    <= SP_RST;
		end else begin
			unique case (state_r)
				SQ_IDLE: begin
					if (wr_go && (PADDR_I == OFS_PC))
						pc_r <= PWDATA_I[15:0];
					if (wr_go && (PADDR_I == OFS_SP))
						sp_r <= PWDATA_I[15:0];
					if (take) begin
						hi_r    <= 1'b1;
						vec_r   <= fixed_vec(src);
						state_r <= (src == SRC_GEN) ? SQ_ACK1 : SQ_PSH1;
					end
				end
				SQ_ACK1: begin
					if (pif.tick)
						state_r <= SQ_ACK2;
				end
				SQ_ACK2: begin
					if (pif.tick)
						state_r <= SQ_ACK3;
				end
				SQ_ACK3: begin
					if (pif.tick) begin
						vec_ld_r <= 1'b1;
						state_r  <= SQ_PSH1;
					end
				end
				SQ_PSH1: begin
					if (pif.tick) begin
						// Opcode byte needs the synchroniser's four clocks to arrive
						if (vec_ld_r) begin
							vec_r    <= 16'(pif.ad[5:3]) * RST_SPACE;
							vec_ld_r <= 1'b0;
						end
						state_r <= SQ_PSH2;
					end
				end
				SQ_PSH2: begin
					if (pif.tick)
						state_r <= SQ_PSH3;
				end
				SQ_PSH3: begin
					if (pif.tick) begin
						sp_r <= sp_r - 16'h0001;
						if (hi_r) begin
							hi_r    <= 1'b0;
							state_r <= SQ_PSH1;
						end else begin
							pc_r    <= vec_r;
							state_r <= SQ_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ==========================================
	// Bus pins, one clock behind the state
	assign bus_addr = ((state_r == SQ_ACK1) || (state_r == SQ_ACK2) || (state_r == SQ_ACK3))
	                  ? pc_r : (sp_r - 16'h0001);

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			ALE_O              <= 1'b0;
			AD_O               <= 8'h00;
			AD_OE_O            <= 1'b0;
			ADDR_HI_O          <= 8'h00;
			WR_N_O             <= 1'b1;
			IRQ_ACK_STROBE_N_O <= 1'b1;
		end else begin
			ALE_O              <= (state_r == SQ_ACK1) || (state_r == SQ_PSH1);
			AD_OE_O            <= (state_r == SQ_ACK1) || (state_r >= SQ_PSH1);
			WR_N_O             <= !((state_r == SQ_PSH2) || (state_r == SQ_PSH3));
			IRQ_ACK_STROBE_N_O <= !((state_r == SQ_ACK2) || (state_r == SQ_ACK3));
			if ((state_r == SQ_ACK1) || (state_r == SQ_PSH1)) begin
				AD_O      <= bus_addr[7:0];
				ADDR_HI_O <= bus_addr[15:8];
			end else if (state_r >= SQ_PSH2) begin
				AD_O <= hi_r ? pc_r[15:8] : pc_r[7:0];
			end
		end
	end

endmodule : ciacu_top

// [dv/ciacu_top_monitor.sv]
`timescale 1ns/10ps
module ciacu_top_monitor (
	// Clock and reset
	input wire logic                         SYS_CLK_I,
	input wire logic                         RESETN_I,
	// Register bus
	input wire logic                         PSEL_I,
	input wire logic                         PENABLE_I,
	input wire logic                         PWRITE_I,
	input wire logic [ciacu_pkg::ADDR_W-1:0] PADDR_I,
	// Pins
	input wire logic                         SERIAL_OUT_LINE_O,
	input wire logic                         ALE_O,
	input wire logic                         AD_OE_O,
	input wire logic                         WR_N_O,
	input wire logic                         IRQ_ACK_STROBE_N_O
);
	import ciacu_pkg::*;
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESETN_I);
	logic cmd_wr;
	assign cmd_wr = PSEL_I && PENABLE_I && PWRITE_I && (PADDR_I == OFS_CMD);
	// ==========================================
	// Bus cycle shape
	property p_ale_addr; ALE_O |-> AD_OE_O && WR_N_O && IRQ_ACK_STROBE_N_O; endproperty
	a_ale_addr: assert property (p_ale_addr) else $error("strobe or float during address state");
	property p_ale_len; $rose(ALE_O) |-> ALE_O [*2] ##1 !ALE_O; endproperty
	a_ale_len: assert property (p_ale_len) else $error("address strobe not one state long");
	property p_ale_next; $rose(ALE_O) |-> ##2 (!WR_N_O || !IRQ_ACK_STROBE_N_O); endproperty
	a_ale_next: assert property (p_ale_next) else $error("no data strobe after address state");
	property p_wr_len; $fell(WR_N_O) |-> (!WR_N_O && AD_OE_O) [*4] ##1 WR_N_O; endproperty
	a_wr_len: assert property (p_wr_len) else $error("push write strobe wrong length");
	// ==========================================
	// Acknowledge and serial output
	property p_ack_float;
		$fell(IRQ_ACK_STROBE_N_O) |-> (!IRQ_ACK_STROBE_N_O && !AD_OE_O) [*4] ##1 IRQ_ACK_STROBE_N_O;
	endproperty
	a_ack_float: assert property (p_ack_float) else $error("acknowledge strobe or bus drive wrong");
	property p_ack_push; $rose(IRQ_ACK_STROBE_N_O) |-> ##[1:8] !WR_N_O; endproperty
	a_ack_push: assert property (p_ack_push) else $error("no push after acknowledge");
	property p_strobe_excl; !(!WR_N_O && !IRQ_ACK_STROBE_N_O); endproperty
	a_strobe_excl: assert property (p_strobe_excl) else $error("write and acknowledge together");
	property p_sod_cause; $changed(SERIAL_OUT_LINE_O) |-> $past(cmd_wr) || $past(cmd_wr, 2); endproperty
	a_sod_cause: assert property (p_sod_cause) else $error("serial output moved without command");
endmodule : ciacu_top_monitor

// [dv/ciacu_periph_model.sv]
`timescale 1ns/10ps
module ciacu_periph_model (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	// Bench requests: nmi, c, b, a, general
	input  wire logic [4:0] raise_i,
	input  wire logic [2:0] vec_i,
	// Device bus
	input  wire logic       wr_n_i,
	input  wire logic       ack_n_i,
	input  wire logic       ad_oe_i,
	input  wire logic [7:0] dev_ad_i,
	// Pins
	output logic [4:0]      req_o,
	output logic [7:0]      bus_o,
	output logic [15:0]     pushed_o
);
	logic [4:0] lvl_r;
	logic [2:0] cnt_r;
	logic       wr_r;
	logic       half_r;
	logic [7:0] last_r;
	logic [4:0] drop;
	logic       push;
	// Service retires the highest level held other than c
	always_comb begin
		drop = 5'h00;
		if (lvl_r[4]) drop[4] = 1'b1;
		else if (lvl_r[2]) drop[2] = 1'b1;
		else if (lvl_r[1]) drop[1] = 1'b1;
		else drop[0] = lvl_r[0];
	end
	assign push = wr_r && !wr_n_i && !half_r;
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			lvl_r <= 5'h00;
			cnt_r <= 3'h0;
			wr_r <= 1'b1;
			half_r <= 1'b0;
			last_r <= 8'h00;
			pushed_o <= 16'h0000;
		end else begin
			wr_r <= wr_n_i;
			if (ad_oe_i || !ack_n_i) last_r <= bus_o;
			if (wr_r && !wr_n_i) pushed_o <= {pushed_o[7:0], dev_ad_i};
			if (wr_r && !wr_n_i) half_r <= !half_r;
			// Held high until the first push write
			lvl_r <= raise_i | (lvl_r & ~(push ? drop : 5'h00));
			if (raise_i[3]) cnt_r <= 3'h6;
			else if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
		end
	end
	// Restart c is a short pulse only
	assign req_o = {lvl_r[4], cnt_r != 3'h0, lvl_r[2:0]};
	// Undriven bus shows the opposite level, so a late opcode sample shows up
	assign bus_o = ad_oe_i ? dev_ad_i : (!ack_n_i ? {2'b11, vec_i, 3'b111} : ~last_r);
endmodule : ciacu_periph_model

// [dv/ciacu_top_tb.sv]
`timescale 1ns/10ps
bind ciacu_top ciacu_top_monitor ciacu_top_monitor_inst (.SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I),
	.PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
	.SERIAL_OUT_LINE_O(SERIAL_OUT_LINE_O), .ALE_O(ALE_O), .AD_OE_O(AD_OE_O), .WR_N_O(WR_N_O),
	.IRQ_ACK_STROBE_N_O(IRQ_ACK_STROBE_N_O));
module ciacu_top_tb;
	import ciacu_pkg::*;
	localparam logic [7:0] ACC = OFS_GPR + {3'h0, CODE_A, 2'h0};
	logic        clk;
	logic        rstn;
	logic        psel;
	logic        pen;
	logic        pwr;
	logic        sin;
	logic        pready;
	logic        serial_out_line;
	logic        pslverr;
	logic        rerr;
	logic        hold;
	logic        ad_oe;
	logic        ale;
	logic        wr_n;
	logic        ack_n;
	logic [7:0]  paddr;
	logic [7:0]  ad_o;
	logic [7:0]  ad_in;
	logic [15:0] pushed;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rdata;
	logic [4:0]  raise;
	logic [4:0]  req;
	logic [2:0]  vec;
	int          num_errors;
	int          compares;
	ciacu_top ciacu_top_inst (.SYS_CLK_I(clk), .RESETN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .NMI_REQ_I(req[4]), .RESTART_C_I(req[3]), .RESTART_B_I(req[2]),
		.RESTART_A_I(req[1]), .GENERAL_REQUEST_I(req[0]), .HOLD_REQ_I(hold), .SERIAL_IN_LINE_I(sin),
		.SERIAL_OUT_LINE_O(serial_out_line), .AD_I(ad_in), .AD_O(ad_o), .AD_OE_O(ad_oe), .ADDR_HI_O(),
		.ALE_O(ale), .WR_N_O(wr_n), .IRQ_ACK_STROBE_N_O(ack_n));
	ciacu_periph_model ciacu_periph_model_inst (.clk_i(clk), .resetn_i(rstn), .raise_i(raise),
		.vec_i(vec), .wr_n_i(wr_n), .ack_n_i(ack_n), .ad_oe_i(ad_oe), .dev_ad_i(ad_o),
		.req_o(req), .bus_o(ad_in), .pushed_o(pushed));
	// ==========================================
	// Common tasks
	task automatic stop_test();
		$display("compares=%0d num_errors=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Entered just after a rising edge; leaves one idle edge behind
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
		if (n >= 20) begin
			num_errors++;
			stop_test();
		end
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdata, e);
	endtask : rd
	task automatic fire(input logic [4:0] r, input logic [2:0] v);
		vec <= v;
		raise <= r;
		@(posedge clk);
		raise <= 5'h00;
	endtask : fire
	// Polls status until a service has run and the sequencer is free
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, OFS_STAT, 32'h0);
			n++;
		end while ((rdata[STAT_BUSY] !== 1'b0 || rdata[STAT_IE] !== 1'b0) && n < 100);
		if (n >= 100) begin
			num_errors++;
			stop_test();
		end
	endtask : wait_idle
	// ==========================================
	// Scenarios
	task automatic s_mask();
		sin <= 1'b1;
		rd(OFS_STAT, 32'h7);
		hold <= 1'b1;
		chk({31'h0, serial_out_line}, 32'h0);
		apb(1'b1, ACC, 32'hc8);
		apb(1'b1, OFS_CMD, 32'h4);
		apb(1'b1, OFS_STAT, 32'h7);
		chk({31'h0, rerr}, 32'h1);
		rd(OFS_STAT, 32'h140);
		hold <= 1'b0;
		chk({31'h0, serial_out_line}, 32'h1);
		apb(1'b1, OFS_CMD, 32'h8);
		rd(ACC, 32'h80);
	endtask : s_mask
	task automatic s_pend();
		apb(1'b1, ACC, 32'h0f);
		apb(1'b1, OFS_CMD, 32'h4);
		fire(5'h08, 3'h0);
		repeat (8) @(posedge clk);
		rd(OFS_STAT, 32'h117);
		apb(1'b1, OFS_PC, 32'h1234);
		apb(1'b1, OFS_SP, 32'h2000);
		apb(1'b1, ACC, 32'h08);
		apb(1'b1, OFS_CMD, 32'h5);
		wait_idle();
		rd(OFS_PC, 32'h3c);
		rd(OFS_SP, 32'h1ffe);
		chk({16'h0, pushed}, 32'h1234);
		rd(OFS_STAT, 32'h100);
	endtask : s_pend
	task automatic s_prio();
		fire(5'h06, 3'h0);
		repeat (20) @(posedge clk);
		rd(OFS_PC, 32'h3c);
		apb(1'b1, OFS_CMD, 32'h1);
		wait_idle();
		rd(OFS_PC, 32'h34);
		apb(1'b1, OFS_CMD, 32'h1);
		wait_idle();
		rd(OFS_PC, 32'h2c);
		rd(OFS_SP, 32'h1ffa);
		fire(5'h08, 3'h0);
		repeat (8) @(posedge clk);
		rd(OFS_STAT, 32'h110);
		apb(1'b1, ACC, 32'h10);
		apb(1'b1, OFS_CMD, 32'h4);
		rd(OFS_STAT, 32'h100);
	endtask : s_prio
	task automatic s_trap_gen();
		apb(1'b1, OFS_CMD, 32'h1);
		fire(5'h10, 3'h0);
		wait_idle();
		rd(OFS_PC, 32'h24);
		apb(1'b1, OFS_CMD, 32'h8);
		rd(ACC, 32'h88);
		apb(1'b1, OFS_CMD, 32'h8);
		rd(ACC, 32'h80);
		apb(1'b1, OFS_CMD, 32'h1);
		fire(5'h01, 3'h5);
		wait_idle();
		rd(OFS_PC, 32'h28);
		rd(OFS_SP, 32'h1ff6);
		chk({16'h0, pushed}, 32'h24);
	endtask : s_trap_gen
	// ==========================================
	// Clock, reset and sequence
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sin = 1'b0;
		hold = 1'b0;
		raise = 5'h00;
		vec = 3'h0;
		num_errors = 0;
		compares = 0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		s_mask();
		s_pend();
		s_prio();
		s_trap_gen();
		stop_test();
	end
endmodule : ciacu_top_tb
